// *** rtl/timer_pair_pkg.sv ***
package timer_pair_pkg;
    // register offsets
    localparam logic [7:0] ADDR_RUN_CTRL = 8'h88;
    localparam logic [7:0] ADDR_MODE_CTRL = 8'h89;
    localparam logic [7:0] ADDR_COUNT_A_LOW = 8'h8a;
    localparam logic [7:0] ADDR_COUNT_B_LOW = 8'h8b;
    localparam logic [7:0] ADDR_COUNT_A_HIGH = 8'h8c;
    localparam logic [7:0] ADDR_CLOCK_CTRL = 8'h8e;
    localparam logic [7:0] ADDR_IRQ_PIN_CFG = 8'he4;

    // field positions
    localparam int RUN_A_BIT = 4;
    localparam int RUN_B_BIT = 6;
    localparam int GATE_BIT = 3;
    localparam int SOURCE_BIT = 2;
    localparam int MODE_LSB = 0;
    localparam int PRESCALE_BIT = 2;
    localparam int POLARITY_BIT = 3;

    // writable bits of each control register, others read as zero
    localparam logic [7:0] RUN_CTRL_MASK = 8'h50;
    localparam logic [7:0] MODE_CTRL_MASK = 8'h0f;
    localparam logic [7:0] CLOCK_CTRL_MASK = 8'h04;
    localparam logic [7:0] IRQ_PIN_CFG_MASK = 8'h08;

    // values after reset
    localparam logic [7:0] RESET_BYTE = 8'h00;

    // operation modes
    typedef enum logic [1:0] {
        MODE_13BIT = 2'h0,
        MODE_16BIT = 2'h1,
        MODE_8BIT_RELOAD = 2'h2,
        MODE_SPLIT = 2'h3
    } op_mode_e;

    // internal prescaler: one tick every PRESCALE_DIV system clocks
    localparam int PRESCALE_W = 4;
    localparam logic [PRESCALE_W-1:0] PRESCALE_DIV = 4'hc;
    localparam logic [PRESCALE_W-1:0] PRESCALE_LAST = PRESCALE_DIV - 4'h1;
    localparam logic [PRESCALE_W-1:0] PRESCALE_RESET = 4'h0;
endpackage

// *** rtl/pin_sync_if.sv ***
`timescale 1ns/100ps
interface pin_sync_if;
    logic evtFall;
    logic irqLevel;
    modport sync (output evtFall, output irqLevel);
    modport core (input evtFall, input irqLevel);
endinterface

// *** rtl/pin_sync.sv ***
`timescale 1ns/100ps
module pin_sync (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic ce,
    input wire logic eventCountInputPin,
    input wire logic extIrqPinA,
    pin_sync_if.sync pins
);
    logic evtMeta_q;
    logic evtSync_q;
    logic evtLast_q;
    logic irqMeta_q;
    logic irqSync_q;

    // two stages ahead of any logic, then one more for edge detection
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            evtMeta_q <= 1'b0;
            evtSync_q <= 1'b0;
            evtLast_q <= 1'b0;
            irqMeta_q <= 1'b0;
            irqSync_q <= 1'b0;
        end else if (ce) begin
            evtMeta_q <= eventCountInputPin;
            evtSync_q <= evtMeta_q;
            evtLast_q <= evtSync_q;
            irqMeta_q <= extIrqPinA;
            irqSync_q <= irqMeta_q;
        end
    end

    // one pulse per high-to-low transition
    assign pins.evtFall = evtLast_q && !evtSync_q;
    assign pins.irqLevel = irqSync_q;
endmodule

// *** rtl/gated_counter_timer_pair.sv ***
`timescale 1ns/100ps
// Behaviour
// - gate select 0: timer A counts whenever run control is 1, pin ignored
// - gate select 1: counts only with run set and irq pin at chosen polarity
// - source select 0: counts internal clock picked by prescale select bit
// - source select 1: counts each falling edge on the event count pin
// - mode 00 gives 13-bit counting, mode 01 gives 16-bit counting
// - mode 10: 8-bit counter reloaded from the high byte on overflow
// - mode 11: timer A splits into two independent 8-bit counters
// - timer A low byte is a read/write register, reset to zero
// - timer B low byte is a read/write register, reset to zero
module gated_counter_timer_pair (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic ce,
    input wire logic [7:0] addr,
    input wire logic [7:0] wrData,
    input wire logic wrEn,
    input wire logic rdEn,
    output logic [7:0] rdData,
    input wire logic eventCountInputPin,
    input wire logic extIrqPinA,
    output logic overflowA,
    output logic overflowHigh
);
    function automatic logic isAddr(input logic [7:0] a, input logic [7:0] offset);
        isAddr = (a == offset);
    endfunction

    pin_sync_if pins ();

    pin_sync u_pin_sync (
        .clk(clk),
        .reset_n(reset_n),
        .ce(ce),
        .eventCountInputPin(eventCountInputPin),
        .extIrqPinA(extIrqPinA),
        .pins(pins.sync)
    );

    logic [7:0] runCtrl_q;
    logic [7:0] modeCtrl_q;
    logic [7:0] clockCtrl_q;
    logic [7:0] irqPinCfg_q;
    logic [7:0] timerACountLow_q;
    logic [7:0] timerACountLow_d;
    logic [7:0] timerACountHigh_q;
    logic [7:0] timerACountHigh_d;
    logic [7:0] timerBCountLow_q;
    logic [7:0] rdData_q;
    logic [7:0] rdData_d;
    logic overflowA_q;
    logic overflowA_d;
    logic overflowHigh_q;
    logic overflowHigh_d;
    logic [timer_pair_pkg::PRESCALE_W-1:0] prescale_q;

    // address decode
    wire selRun = isAddr(addr, timer_pair_pkg::ADDR_RUN_CTRL);
    wire selMode = isAddr(addr, timer_pair_pkg::ADDR_MODE_CTRL);
    wire selALow = isAddr(addr, timer_pair_pkg::ADDR_COUNT_A_LOW);
    wire selBLow = isAddr(addr, timer_pair_pkg::ADDR_COUNT_B_LOW);
    wire selAHigh = isAddr(addr, timer_pair_pkg::ADDR_COUNT_A_HIGH);
    wire selClock = isAddr(addr, timer_pair_pkg::ADDR_CLOCK_CTRL);
    wire selIrqCfg = isAddr(addr, timer_pair_pkg::ADDR_IRQ_PIN_CFG);
    wire wrALow = wrEn && selALow;
    wire wrAHigh = wrEn && selAHigh;

    // control fields
    wire runControlBit = runCtrl_q[timer_pair_pkg::RUN_A_BIT];
    wire runControlB = runCtrl_q[timer_pair_pkg::RUN_B_BIT];
    wire gateByPinSelect = modeCtrl_q[timer_pair_pkg::GATE_BIT];
    wire countSourceSelect = modeCtrl_q[timer_pair_pkg::SOURCE_BIT];
    wire [1:0] operationModeField = modeCtrl_q[timer_pair_pkg::MODE_LSB +: 2];
    wire prescaleSelectBit = clockCtrl_q[timer_pair_pkg::PRESCALE_BIT];
    wire irqPinPolarity = irqPinCfg_q[timer_pair_pkg::POLARITY_BIT];
    timer_pair_pkg::op_mode_e mode;
    assign mode = timer_pair_pkg::op_mode_e'(operationModeField);

    // internal count clock
    wire prescaleWrap = (prescale_q == timer_pair_pkg::PRESCALE_LAST);
    wire internalTick = prescaleSelectBit || prescaleWrap;

    // gating and count source
    wire pinActive = (pins.irqLevel == irqPinPolarity);
    wire gateOpen = !gateByPinSelect || pinActive;
    wire countEvent = countSourceSelect ? pins.evtFall : internalTick;
    wire incA = runControlBit && gateOpen && countEvent;
    wire incHigh = runControlB && internalTick;

    // adders for each width
    wire [13:0] sum13 = {1'b0, timerACountHigh_q, timerACountLow_q[4:0]} + 14'h0001;
    wire [16:0] sum16 = {1'b0, timerACountHigh_q, timerACountLow_q} + 17'h00001;
    wire [8:0] sumLow = {1'b0, timerACountLow_q} + 9'h001;
    wire [8:0] sumHigh = {1'b0, timerACountHigh_q} + 9'h001;

    always_comb begin
        timerACountLow_d = timerACountLow_q;
        timerACountHigh_d = timerACountHigh_q;
        overflowA_d = 1'b0;
        overflowHigh_d = 1'b0;
        unique case (mode)
            timer_pair_pkg::MODE_13BIT: begin
                if (incA) begin
                    timerACountLow_d = {timerACountLow_q[7:5], sum13[4:0]};
                    timerACountHigh_d = sum13[12:5];
                    overflowA_d = sum13[13];
                end
            end
            timer_pair_pkg::MODE_16BIT: begin
                if (incA) begin
                    timerACountLow_d = sum16[7:0];
                    timerACountHigh_d = sum16[15:8];
                    overflowA_d = sum16[16];
                end
            end
            timer_pair_pkg::MODE_8BIT_RELOAD: begin
                if (incA) begin
                    timerACountLow_d = sumLow[8] ? timerACountHigh_q : sumLow[7:0];
                    overflowA_d = sumLow[8];
                end
            end
            timer_pair_pkg::MODE_SPLIT: begin
                if (incA) begin
                    timerACountLow_d = sumLow[7:0];
                    overflowA_d = sumLow[8];
                end
                if (incHigh) begin
                    timerACountHigh_d = sumHigh[7:0];
                    overflowHigh_d = sumHigh[8];
                end
            end
        endcase
        // a software write wins over a count in the same cycle
        if (wrALow) begin
            timerACountLow_d = wrData;
        end
        if (wrAHigh) begin
            timerACountHigh_d = wrData;
        end
    end

    // read mux, unmapped addresses read zero
    always_comb begin
        rdData_d = 8'h00;
        if (selRun) begin
            rdData_d = runCtrl_q;
        end else if (selMode) begin
            rdData_d = modeCtrl_q;
        end else if (selALow) begin
            rdData_d = timerACountLow_q;
        end else if (selBLow) begin
            rdData_d = timerBCountLow_q;
        end else if (selAHigh) begin
            rdData_d = timerACountHigh_q;
        end else if (selClock) begin
            rdData_d = clockCtrl_q;
        end else if (selIrqCfg) begin
            rdData_d = irqPinCfg_q;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            runCtrl_q <= timer_pair_pkg::RESET_BYTE;
            modeCtrl_q <= timer_pair_pkg::RESET_BYTE;
            clockCtrl_q <= timer_pair_pkg::RESET_BYTE;
            irqPinCfg_q <= timer_pair_pkg::RESET_BYTE;
        end else if (ce && wrEn) begin
            if (selRun) runCtrl_q <= wrData & timer_pair_pkg::RUN_CTRL_MASK;
            if (selMode) modeCtrl_q <= wrData & timer_pair_pkg::MODE_CTRL_MASK;
            if (selClock) clockCtrl_q <= wrData & timer_pair_pkg::CLOCK_CTRL_MASK;
            if (selIrqCfg) irqPinCfg_q <= wrData & timer_pair_pkg::IRQ_PIN_CFG_MASK;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            timerACountLow_q <= timer_pair_pkg::RESET_BYTE;
            timerACountHigh_q <= timer_pair_pkg::RESET_BYTE;
            timerBCountLow_q <= timer_pair_pkg::RESET_BYTE;
            overflowA_q <= 1'b0;
            overflowHigh_q <= 1'b0;
        end else if (ce) begin
            timerACountLow_q <= timerACountLow_d;
            timerACountHigh_q <= timerACountHigh_d;
            overflowA_q <= overflowA_d;
            overflowHigh_q <= overflowHigh_d;
            if (wrEn && selBLow) timerBCountLow_q <= wrData;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            prescale_q <= timer_pair_pkg::PRESCALE_RESET;
        end else if (ce) begin
            prescale_q <= prescaleWrap ? timer_pair_pkg::PRESCALE_RESET
                                       : prescale_q + 4'h1;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rdData_q <= timer_pair_pkg::RESET_BYTE;
        end else if (ce) begin
            rdData_q <= rdEn ? rdData_d : 8'h00;
        end
    end

    assign rdData = rdData_q;
    assign overflowA = overflowA_q;
    assign overflowHigh = overflowHigh_q;

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    wire quietA = ce && !wrALow && !wrAHigh;

    sequence s_step16;
        quietA && mode == timer_pair_pkg::MODE_16BIT && runControlBit;
    endsequence

    sequence s_reloadEdge;
        quietA && mode == timer_pair_pkg::MODE_8BIT_RELOAD && incA
            && timerACountLow_q == 8'hff;
    endsequence

    sequence s_gatedEvent;
        quietA && gateByPinSelect && pinActive && countSourceSelect && pins.evtFall;
    endsequence

    AST_GATE_OFF_COUNTS: assert property (
        s_step16 and (!gateByPinSelect && !countSourceSelect && prescaleSelectBit)
        |=> timerACountLow_q == 8'($past(timerACountLow_q) + 8'h01))
        else $error("timer did not count with gate select clear");

    AST_GATE_BLOCKS: assert property (
        quietA && gateByPinSelect && !pinActive
        && mode != timer_pair_pkg::MODE_SPLIT
        |=> $stable(timerACountLow_q) && $stable(timerACountHigh_q))
        else $error("timer counted while pin inactive");

    AST_PRESCALE_GAP: assert property (
        s_step16 and (!countSourceSelect && !prescaleSelectBit && !gateByPinSelect
        && prescaleWrap)
        |=> timerACountLow_q == 8'($past(timerACountLow_q) + 8'h01)
        ##1 ($stable(timerACountLow_q) || $past(wrALow || wrAHigh)))
        else $error("prescaled count rate wrong");

    AST_EVENT_ONLY: assert property (
        quietA && countSourceSelect && !pins.evtFall
        && mode != timer_pair_pkg::MODE_SPLIT
        |=> $stable(timerACountLow_q))
        else $error("event counter moved without a falling edge");

    AST_MODE13_TOP: assert property (
        quietA && mode == timer_pair_pkg::MODE_13BIT
        |=> timerACountLow_q[7:5] == $past(timerACountLow_q[7:5]))
        else $error("13-bit mode touched upper low bits");

    AST_RELOAD: assert property (
        s_reloadEdge |=> timerACountLow_q == $past(timerACountHigh_q) && overflowA)
        else $error("auto reload failed");

    AST_SPLIT_HIGH: assert property (
        quietA && mode == timer_pair_pkg::MODE_SPLIT && incHigh && !incA
        |=> timerACountHigh_q == 8'($past(timerACountHigh_q) + 8'h01)
        && $stable(timerACountLow_q))
        else $error("split high byte not independent");

    AST_A_LOW_RW: assert property (
        ce && wrALow ##1 ce && rdEn && selALow && !wrEn && !incA
        |=> rdData == $past(wrData, 2))
        else $error("timer A low byte write/read mismatch");

    AST_B_LOW_RW: assert property (
        ce && wrEn && selBLow |=> timerBCountLow_q == $past(wrData))
        else $error("timer B low byte not written");

    AST_ONE_PER_EDGE: assert property (
        pins.evtFall && ce |=> !pins.evtFall)
        else $error("falling edge seen twice");

    AST_GATE_PASSES: assert property (
        s_step16 and s_gatedEvent
        |=> timerACountLow_q == 8'($past(timerACountLow_q) + 8'h01))
        else $error("gated timer missed an edge with pin active");

    AST_MODE16_CARRY: assert property (
        s_step16 and (incA && timerACountLow_q == 8'hff)
        |=> timerACountLow_q == 8'h00
        && timerACountHigh_q == 8'($past(timerACountHigh_q) + 8'h01))
        else $error("16-bit carry into high byte lost");

    AST_SPLIT_WRAP: assert property (
        quietA && mode == timer_pair_pkg::MODE_SPLIT && incHigh
        && timerACountHigh_q == 8'hff
        |=> timerACountHigh_q == 8'h00 && overflowHigh)
        else $error("split high byte wrap not flagged");

    AST_B_LOW_HOLD: assert property (
        !(ce && wrEn && selBLow) |=> $stable(timerBCountLow_q))
        else $error("timer B low byte changed without a write");
endmodule

// *** testbench/tb_gated_counter_timer_pair.sv ***
`timescale 1ns/100ps
module tb_gated_counter_timer_pair;
    logic clk, reset_n, ce, wrEn, rdEn, evPin, irqPin, rdPend;
    logic [7:0] addr, wrData, lo;
    wire logic [7:0] rdData;
    wire logic overflowA, overflowHigh;
    int miscompares = 0;
    int n_checks = 0;
    int ovfCount = 0;
    int ovfHighCount = 0;
    logic [7:0] expLo[$];
    string expName[$];
    string nm;
    logic [7:0] lowExp [4] = '{8'he0, 8'h00, 8'h40, 8'h00};
    logic [7:0] highExp [4] = '{8'h41, 8'h41, 8'h40, 8'h40};

    gated_counter_timer_pair dut (.clk(clk), .reset_n(reset_n), .ce(ce), .addr(addr),
        .wrData(wrData), .wrEn(wrEn), .rdEn(rdEn), .rdData(rdData),
        .eventCountInputPin(evPin), .extIrqPinA(irqPin), .overflowA(overflowA),
        .overflowHigh(overflowHigh));

    initial begin
        clk = 1'b0;
        forever begin
            #25 clk = ~clk;
        end
    end

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic results;
        if (miscompares == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // bus cycles: strobes are set once per step, never lowered inside
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        addr <= a;
        wrData <= d;
        wrEn <= 1'b1;
        rdEn <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e, input string what);
        expLo.push_back(e);
        expName.push_back(what);
        addr <= a;
        wrEn <= 1'b0;
        rdEn <= 1'b1;
        @(posedge clk);
    endtask

    task automatic idle(input int n);
        wrEn <= 1'b0;
        rdEn <= 1'b0;
        repeat (n) @(posedge clk);
    endtask

    task automatic pulses(input int n);
        repeat (n) begin
            evPin <= 1'b0;
            idle(3);
            evPin <= 1'b1;
            idle(3);
        end
        idle(4);
    endtask

    // result watcher: read data stand in the cycle after the strobe
    always @(posedge clk) begin
        rdPend <= rdEn & ce;
        if (overflowA === 1'b1)
            ovfCount++;
        if (overflowHigh === 1'b1)
            ovfHighCount++;
    end

    always @(negedge clk) begin
        if (rdPend === 1'b1 && expLo.size() > 0) begin
            lo = expLo.pop_front();
            nm = expName.pop_front();
            check(nm, rdData, lo);
        end
    end

    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        results();
    end

    initial begin
        int r, k, m;
        logic [7:0] v;
        reset_n = 1'b0;
        ce = 1'b1;
        addr = 8'h00;
        wrData = 8'h00;
        wrEn = 1'b0;
        rdEn = 1'b0;
        evPin = 1'b1;
        irqPin = 1'b0;
        r = $urandom(65715);
        repeat (10) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        rd(timer_pair_pkg::ADDR_COUNT_A_LOW, 8'h00, "countALowReset");
        rd(timer_pair_pkg::ADDR_COUNT_B_LOW, 8'h00, "countBLowReset");
        rd(8'h77, 8'h00, "unmappedRead");
        v = 8'($urandom);
        wr(timer_pair_pkg::ADDR_COUNT_B_LOW, v);
        rd(timer_pair_pkg::ADDR_COUNT_B_LOW, v, "countBLowWrite");
        ce <= 1'b0;
        wr(timer_pair_pkg::ADDR_COUNT_B_LOW, ~v);
        ce <= 1'b1;
        rd(timer_pair_pkg::ADDR_COUNT_B_LOW, v, "countBLowFrozen");
        v = 8'($urandom);
        wr(timer_pair_pkg::ADDR_COUNT_A_LOW, v);
        rd(timer_pair_pkg::ADDR_COUNT_A_LOW, v, "countALowWrite");
        // event counting, gate off, irq pin low
        wr(timer_pair_pkg::ADDR_MODE_CTRL, 8'h05);
        wr(timer_pair_pkg::ADDR_COUNT_A_LOW, 8'h00);
        wr(timer_pair_pkg::ADDR_RUN_CTRL, 8'h10);
        k = 1 + ($urandom % 5);
        pulses(k);
        rd(timer_pair_pkg::ADDR_COUNT_A_LOW, 8'(k), "eventCount");
        // gate on, active high, pin low: no counting
        wr(timer_pair_pkg::ADDR_IRQ_PIN_CFG, 8'h08);
        wr(timer_pair_pkg::ADDR_MODE_CTRL, 8'h0d);
        wr(timer_pair_pkg::ADDR_COUNT_A_LOW, 8'h00);
        pulses(2);
        rd(timer_pair_pkg::ADDR_COUNT_A_LOW, 8'h00, "gatedIdle");
        irqPin <= 1'b1;
        idle(4);
        pulses(3);
        rd(timer_pair_pkg::ADDR_COUNT_A_LOW, 8'h03, "gatedOpen");
        wr(timer_pair_pkg::ADDR_IRQ_PIN_CFG, 8'h00);
        idle(4);
        pulses(2);
        rd(timer_pair_pkg::ADDR_COUNT_A_LOW, 8'h03, "gatedPolarity");
        // internal clock, system clock then divided
        wr(timer_pair_pkg::ADDR_RUN_CTRL, 8'h00);
        wr(timer_pair_pkg::ADDR_CLOCK_CTRL, 8'h04);
        wr(timer_pair_pkg::ADDR_MODE_CTRL, 8'h01);
        wr(timer_pair_pkg::ADDR_COUNT_A_LOW, 8'h00);
        wr(timer_pair_pkg::ADDR_RUN_CTRL, 8'h10);
        idle(19);
        wr(timer_pair_pkg::ADDR_RUN_CTRL, 8'h00);
        rd(timer_pair_pkg::ADDR_COUNT_A_LOW, 8'd20, "sysClockCount");
        wr(timer_pair_pkg::ADDR_CLOCK_CTRL, 8'h00);
        wr(timer_pair_pkg::ADDR_COUNT_A_LOW, 8'h00);
        wr(timer_pair_pkg::ADDR_RUN_CTRL, 8'h10);
        idle(119);
        wr(timer_pair_pkg::ADDR_RUN_CTRL, 8'h00);
        rd(timer_pair_pkg::ADDR_COUNT_A_LOW, 8'd10, "divClockCount");
        // one event from a full low byte in each mode
        for (m = 0; m < 4; m++) begin
            wr(timer_pair_pkg::ADDR_MODE_CTRL, 8'h04 | 8'(m));
            wr(timer_pair_pkg::ADDR_COUNT_A_HIGH, 8'h40);
            wr(timer_pair_pkg::ADDR_COUNT_A_LOW, 8'hff);
            wr(timer_pair_pkg::ADDR_RUN_CTRL, 8'h10);
            pulses(1);
            wr(timer_pair_pkg::ADDR_RUN_CTRL, 8'h00);
            rd(timer_pair_pkg::ADDR_COUNT_A_LOW, lowExp[m], "modeLow");
            rd(timer_pair_pkg::ADDR_COUNT_A_HIGH, highExp[m], "modeHigh");
        end
        // split high byte wraps once on its own run bit, low byte left alone
        wr(timer_pair_pkg::ADDR_CLOCK_CTRL, 8'h04);
        wr(timer_pair_pkg::ADDR_COUNT_A_HIGH, 8'hff);
        wr(timer_pair_pkg::ADDR_RUN_CTRL, 8'h40);
        wr(timer_pair_pkg::ADDR_RUN_CTRL, 8'h00);
        rd(timer_pair_pkg::ADDR_COUNT_A_HIGH, 8'h00, "splitHighWrap");
        rd(timer_pair_pkg::ADDR_COUNT_A_LOW, 8'h00, "splitLowHeld");
        idle(4);
        check("overflowACount", 8'(ovfCount), 8'h02);
        check("overflowHighCount", 8'(ovfHighCount), 8'h01);
        check("pendingReads", 8'(expLo.size()), 8'h00);
        results();
    end
endmodule
